/* sdl_logger.sv */
// Purpose: Sensor logging controller: timer, delay, record packing, error replies
// Assumes: 250 MHz clk; osc_in is the 1024 Hz oscillator from outside this domain
// Notes:   One state struct, one always_comb and one always_ff
`include "sdl_cfg.svh"

// Notes on behaviour
// - Error reply holds flags byte, error code byte and 16-bit checksum only.
// - Codes: unsupported command 01, malformed 02, bad option 03, unknown 0F.
// - Codes: block unavailable 10, relock 11, write to locked block 12.
// - Codes: password A0, params A1, battery A2, temperature A3, user A5, collision A6.
// - Logging form from mode bits 30:29; 00 dense, 01 all-out, 11 crossing, 10 refused.
// - Dense stores every sample, no number, block written after each third sample.
// - Limits forms: temp 9:0, battery 19:10 or zero, 12-bit number above.
// - All-out form records every out-of-limits measurement, skips those inside.
// - Crossing form records only the sample where a limit is crossed outward, not the return inside.
// - Limits forms keep a cumulative out-of-limits count, readable from its own register.
// - Timer from 1024 Hz oscillator; period in seconds, at most 32768.
// - 12-bit start delay loaded by initialize; counts only after start-log.
module sdl_logger #(
  parameter int OSC_HZ       = `SDL_OSC_HZ,
  parameter int DELAY_UNIT_S = `SDL_DELAY_UNIT_S
) (
  input  wire logic              clk,
  input  wire logic              reset,
  input  wire logic [7:0]        addr,
  input  wire logic [31:0]       wdata,
  input  wire logic              wr,
  input  wire logic              rd,
  output logic [31:0]            rdata,
  input  wire logic              osc_in,
  output logic                   meas_req,
  input  wire logic              meas_done,
  input  wire sdl_pkg::sdl_meas_t meas,
  input  wire logic              fault_valid,
  input  wire logic [7:0]        fault_code,
  output logic                   blk_we,
  output sdl_pkg::sdl_blk_t      blk,
  output logic                   err_valid,
  output sdl_pkg::sdl_err_t      err,
  output logic                   irq
);

  // Divider must fit sub_cnt; delay product must fit sec_cnt
  if (OSC_HZ < 2 || OSC_HZ > 65536) begin : g_osc_range
    $error("OSC_HZ out of range");
  end
  if (DELAY_UNIT_S < 1 || DELAY_UNIT_S > 1024) begin : g_unit_range
    $error("DELAY_UNIT_S out of range");
  end

  localparam logic [15:0] SUB_LAST  = 16'(OSC_HZ - 1);
  localparam logic [21:0] UNIT_SECS = 22'(DELAY_UNIT_S);

  sdl_pkg::sdl_state_t q;
  sdl_pkg::sdl_state_t d;

  // Checksum step over one byte, reflected polynomial
  function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] b);
    logic [15:0] r;
    r = c ^ {8'h00, b};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ `SDL_CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction

  // Builds the fixed error frame
  function automatic sdl_pkg::sdl_err_t make_err(input logic [7:0] code);
    sdl_pkg::sdl_err_t e;
    e.flags = `SDL_REPLY_FLAGS;
    e.code  = code;
    e.crc   = ~crc_byte(crc_byte(`SDL_CRC_PRESET, `SDL_REPLY_FLAGS), code);
    return e;
  endfunction

  // Passes listed codes, folds the rest to unknown
  function automatic logic [7:0] known_code(input logic [7:0] c);
    case (c)
      `SDL_ERR_CMD, `SDL_ERR_FMT, `SDL_ERR_OPT, `SDL_ERR_UNK: return c;
      `SDL_ERR_NOBLK, `SDL_ERR_RELOCK, `SDL_ERR_LOCKWR: return c;
      `SDL_ERR_PWD, `SDL_ERR_PARAM, `SDL_ERR_BATT,
      `SDL_ERR_TEMP, `SDL_ERR_USER, `SDL_ERR_COLL: return c;
      default: return `SDL_ERR_UNK;
    endcase
  endfunction

  logic [1:0]  form;
  logic        bchk;
  logic [9:0]  lim_lo;
  logic [9:0]  lim_hi;
  logic        sec_tick;
  logic [7:0]  ec;
  logic [3:0]  evt;
  logic [1:0]  zone;
  logic [31:0] rec;

  always_comb begin
    d          = q;
    d.blk_we   = 1'b0;
    d.err_we   = 1'b0;
    d.meas_req = 1'b0;
    d.rdata    = 32'h0000_0000;
    ec         = 8'h00;
    evt        = 4'h0;
    sec_tick   = 1'b0;
    zone       = 2'b00;
    rec        = 32'h0000_0000;
    form       = q.log_mode[`SDL_FORM_HI:`SDL_FORM_LO];
    bchk       = q.log_mode[`SDL_BATT_BIT];
    lim_lo     = q.limits[9:0];
    lim_hi     = q.limits[19:10];

    // Oscillator crossing and one-second divider
    d.osc_s1 = osc_in;
    d.osc_s2 = q.osc_s1;
    d.osc_s3 = q.osc_s2;
    if (q.osc_s2 && !q.osc_s3) begin
      if (q.sub_cnt == SUB_LAST) begin
        d.sub_cnt = 16'h0000;
        sec_tick  = 1'b1;
      end else begin
        d.sub_cnt = q.sub_cnt + 16'h0001;
      end
    end

    // Register writes
    // Mode and period are frozen once logging starts
    if (wr) begin
      case (addr)
        `SDL_OFF_LOG_MODE:  if (q.phase == sdl_pkg::SDL_IDLE) d.log_mode = wdata;
        `SDL_OFF_LIMITS:    d.limits = wdata;
        `SDL_OFF_INIT_DATA: d.init_data = wdata;
        `SDL_OFF_PERIOD:    if (q.phase == sdl_pkg::SDL_IDLE) d.period = wdata[15:0];
        `SDL_OFF_IRQ_MASK:  d.irq_mask = wdata[3:0];
        `SDL_OFF_CMD: begin
          if (wdata[31:8] != 24'h000000) begin
            ec = `SDL_ERR_FMT;
          end else begin
            case (wdata[7:0])
              `SDL_CMD_INIT: begin
                d.delay     = q.init_data[11:0];
                d.params_ok = 1'b1;
              end
              `SDL_CMD_STATE: ;
              `SDL_CMD_START: begin
                // A refused start leaves every setting as it was
                if (!q.params_ok) begin
                  ec = `SDL_ERR_PARAM;
                end else if (form == 2'b10) begin
                  ec = `SDL_ERR_OPT;
                end else if (q.period == 16'h0000 || q.period > `SDL_PERIOD_MAX) begin
                  ec = `SDL_ERR_OPT;
                end else begin
                  d.phase   = sdl_pkg::SDL_DELAY;
                  d.sec_cnt = 22'(q.delay) * UNIT_SECS;
                  d.idx     = 12'h000;
                  d.slot    = 2'b00;
                  d.pack    = 20'h00000;
                  d.zone    = 2'b00;
                  d.ool_cnt = 32'h0000_0000;
                  // Delay counts whole seconds from the start command
                  d.sub_cnt = 16'h0000;
                end
              end
              default: ec = `SDL_ERR_CMD;
            endcase
          end
        end
        default: ;
      endcase
    end

    // Delay countdown, then one measurement per period
    // Run begins on the tick after the delay count reaches zero
    case (q.phase)
      sdl_pkg::SDL_DELAY: begin
        if (sec_tick) begin
          if (q.sec_cnt == 22'h000000) begin
            d.phase   = sdl_pkg::SDL_RUN;
            d.sec_cnt = 22'(q.period - 16'h0001);
            evt[`SDL_EVT_RUN] = 1'b1;
          end else begin
            d.sec_cnt = q.sec_cnt - 22'h000001;
          end
        end
      end
      sdl_pkg::SDL_RUN: begin
        if (sec_tick) begin
          if (q.sec_cnt == 22'h000000) begin
            d.sec_cnt  = 22'(q.period - 16'h0001);
            d.idx      = q.idx + 12'h001;
            d.meas_req = 1'b1;
          end else begin
            d.sec_cnt = q.sec_cnt - 22'h000001;
          end
        end
      end
      default: ;
    endcase

    // Result handling
    if (meas_done && q.phase == sdl_pkg::SDL_RUN) begin
      // Zone 01 below the window, 10 above it, 00 inside
      if (meas.temp < lim_lo) zone = 2'b01;
      else if (meas.temp > lim_hi) zone = 2'b10;
      // Dense holds two samples back and writes on the third
      if (form == 2'b00) begin
        case (q.slot)
          2'b00: begin
            d.pack[9:0] = meas.temp;
            d.slot      = 2'b01;
          end
          2'b01: begin
            d.pack[19:10] = meas.temp;
            d.slot        = 2'b10;
          end
          default: begin
            rec      = {2'b00, meas.temp, q.pack};
            d.blk_we = 1'b1;
            d.slot   = 2'b00;
          end
        endcase
      end else begin
        // Number counts periods since start; first sample is 1
        rec = {q.idx, bchk ? meas.batt : 10'h000, meas.temp};
        if (zone != 2'b00) begin
          d.ool_cnt = q.ool_cnt + 32'h0000_0001;
          evt[`SDL_EVT_OOL] = 1'b1;
        end
        if (form == 2'b01) d.blk_we = (zone != 2'b00);
        else d.blk_we = (zone != 2'b00) && (zone != q.zone);
        d.zone = zone;
      end
      if (d.blk_we) begin
        d.blk.data = rec;
        // Block address wraps at eight bits
        d.blk.addr = q.blk.addr + 8'h01;
        evt[`SDL_EVT_BLOCK] = 1'b1;
      end
      // Command errors outrank sample errors, which outrank faults
      if (meas.temp_err) begin
        ec = (ec == 8'h00) ? `SDL_ERR_TEMP : ec;
      end else if (meas.batt_err && bchk && form != 2'b00) begin
        ec = (ec == 8'h00) ? `SDL_ERR_BATT : ec;
      end
    end

    if (fault_valid && ec == 8'h00) ec = known_code(fault_code);

    if (ec != 8'h00) begin
      d.err    = make_err(ec);
      d.err_we = 1'b1;
      evt[`SDL_EVT_ERROR] = 1'b1;
    end

    // Sticky events, set wins over a same-cycle clear
    d.irq_stat = q.irq_stat;
    if (wr && addr == `SDL_OFF_IRQ_STAT) d.irq_stat = q.irq_stat & ~wdata[3:0];
    d.irq_stat = d.irq_stat | evt;

    // Register reads, answer in the next cycle
    if (rd) begin
      case (addr)
        `SDL_OFF_LOG_MODE:  d.rdata = q.log_mode;
        `SDL_OFF_LIMITS:    d.rdata = q.limits;
        `SDL_OFF_INIT_DATA: d.rdata = q.init_data;
        `SDL_OFF_PERIOD:    d.rdata = {16'h0000, q.period};
        `SDL_OFF_STATUS:    d.rdata = {7'h00, q.params_ok, q.blk.addr, q.idx, 2'b00, q.phase};
        `SDL_OFF_OOL_CNT:   d.rdata = q.ool_cnt;
        `SDL_OFF_ERR_REPLY: d.rdata = q.err;
        `SDL_OFF_IRQ_STAT:  d.rdata = {28'h0000000, q.irq_stat};
        `SDL_OFF_IRQ_MASK:  d.rdata = {28'h0000000, q.irq_mask};
        `SDL_OFF_LAST_BLK:  d.rdata = q.blk.data;
        default:            d.rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      q           <= '0;
      q.phase     <= sdl_pkg::SDL_IDLE;
      q.period    <= `SDL_PERIOD_RST;
      // One below the first block, so the first write lands at 00
      q.blk.addr  <= 8'hFF;
    end else begin
      q <= d;
    end
  end

  assign rdata     = q.rdata;
  assign meas_req  = q.meas_req;
  assign blk_we    = q.blk_we;
  assign blk       = q.blk;
  assign err_valid = q.err_we;
  assign err       = q.err;
  assign irq       = |(q.irq_stat & q.irq_mask);

endmodule // sdl_logger

/* sdl_cfg.svh */
// Purpose: Offsets, field positions, reset values and codes of the logger
// Assumes: Byte addresses on an 8-bit register port, one word each
// Notes:   Definitions only
`ifndef SDL_CFG_SVH
`define SDL_CFG_SVH
`define SDL_OFF_CMD       8'h00
`define SDL_OFF_LOG_MODE  8'h04
`define SDL_OFF_LIMITS    8'h08
`define SDL_OFF_INIT_DATA 8'h0C
`define SDL_OFF_PERIOD    8'h10
`define SDL_OFF_STATUS    8'h14
`define SDL_OFF_OOL_CNT   8'h18
`define SDL_OFF_ERR_REPLY 8'h1C
`define SDL_OFF_IRQ_STAT  8'h20
`define SDL_OFF_IRQ_MASK  8'h24
`define SDL_OFF_LAST_BLK  8'h28
`define SDL_FORM_HI       30
`define SDL_FORM_LO       29
`define SDL_BATT_BIT      28
`define SDL_PERIOD_RST    16'h0001
`define SDL_PERIOD_MAX    16'h8000
`define SDL_OSC_HZ        1024
`define SDL_DELAY_UNIT_S  512
`define SDL_CMD_START     8'hA7
`define SDL_CMD_STATE     8'hA8
`define SDL_CMD_INIT      8'hAC
`define SDL_ERR_CMD       8'h01
`define SDL_ERR_FMT       8'h02
`define SDL_ERR_OPT       8'h03
`define SDL_ERR_UNK       8'h0F
`define SDL_ERR_NOBLK     8'h10
`define SDL_ERR_RELOCK    8'h11
`define SDL_ERR_LOCKWR    8'h12
`define SDL_ERR_PWD       8'hA0
`define SDL_ERR_PARAM     8'hA1
`define SDL_ERR_BATT      8'hA2
`define SDL_ERR_TEMP      8'hA3
`define SDL_ERR_USER      8'hA5
`define SDL_ERR_COLL      8'hA6
`define SDL_REPLY_FLAGS   8'h01
`define SDL_CRC_PRESET    16'hFFFF
`define SDL_CRC_POLY      16'h8408
`define SDL_EVT_BLOCK     0
`define SDL_EVT_ERROR     1
`define SDL_EVT_OOL       2
`define SDL_EVT_RUN       3
`endif

/* sdl_pkg.sv */
// Purpose: Types shared by the logger and its bench
// Assumes: Widths fixed at the documented sizes
// Notes:   Constants live in sdl_cfg.svh
package sdl_pkg;
  typedef enum logic [1:0] {SDL_IDLE, SDL_DELAY, SDL_RUN} sdl_phase_t;

  typedef struct packed {
    logic [9:0] temp;
    logic [9:0] batt;
    logic       temp_err;
    logic       batt_err;
  } sdl_meas_t;

  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] data;
  } sdl_blk_t;

  typedef struct packed {
    logic [15:0] crc;
    logic [7:0]  code;
    logic [7:0]  flags;
  } sdl_err_t;

  typedef struct packed {
    logic        osc_s1;
    logic        osc_s2;
    logic        osc_s3;
    sdl_phase_t  phase;
    logic [15:0] sub_cnt;
    logic [21:0] sec_cnt;
    logic [31:0] log_mode;
    logic [31:0] limits;
    logic [31:0] init_data;
    logic [15:0] period;
    logic [11:0] delay;
    logic        params_ok;
    logic [11:0] idx;
    logic [1:0]  slot;
    logic [19:0] pack;
    logic [1:0]  zone;
    logic [31:0] ool_cnt;
    logic        blk_we;
    sdl_blk_t    blk;
    logic        err_we;
    sdl_err_t    err;
    logic        meas_req;
    logic [3:0]  irq_stat;
    logic [3:0]  irq_mask;
    logic [31:0] rdata;
  } sdl_state_t;
endpackage

/* sdl_logger_chk.sv */
// Purpose: Port-level assertions for sdl_logger
// Assumes: Log mode is only written while the logger is idle
// Notes:   Bound to every sdl_logger instance
`include "sdl_cfg.svh"
module sdl_logger_chk (
  input wire logic               clk,
  input wire logic               reset,
  input wire logic [7:0]         addr,
  input wire logic [31:0]        wdata,
  input wire logic               wr,
  input wire logic               rd,
  input wire logic [31:0]        rdata,
  input wire logic               meas_req,
  input wire logic               meas_done,
  input wire logic               fault_valid,
  input wire logic [7:0]         fault_code,
  input wire logic               blk_we,
  input wire sdl_pkg::sdl_blk_t  blk,
  input wire logic               err_valid,
  input wire sdl_pkg::sdl_err_t  err
);
  logic [31:0] mode_q;
  logic [7:0]  last_q;
  function automatic logic listed(input logic [7:0] c);
    return c inside {8'h01, 8'h02, 8'h03, 8'h0F, 8'h10, 8'h11, 8'h12,
                     8'hA0, 8'hA1, 8'hA2, 8'hA3, 8'hA5, 8'hA6};
  endfunction
  always_ff @(posedge clk) begin
    if (reset) begin
      mode_q <= 32'h0;
      last_q <= 8'hFF;
    end else begin
      if (wr && addr == `SDL_OFF_LOG_MODE) mode_q <= wdata;
      if (blk_we) last_q <= blk.addr;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  sequence s_bad_cmd;
    wr && addr == `SDL_OFF_CMD && wdata[31:8] == 24'h0
      && !(wdata[7:0] inside {`SDL_CMD_START, `SDL_CMD_STATE, `SDL_CMD_INIT});
  endsequence
  sequence s_fmt_cmd;
    wr && addr == `SDL_OFF_CMD && wdata[31:8] != 24'h0;
  endsequence
  sequence s_err(logic [7:0] c);
    err_valid && err.code == c;
  endsequence
  a_rdata_idle: assert property (!$past(rd) |-> rdata == 32'h0)
    else $error("read data outside read cycle");
  a_err_flags: assert property (err_valid |-> err.flags == `SDL_REPLY_FLAGS)
    else $error("error reply flags wrong");
  a_unk_cmd: assert property (s_bad_cmd |=> s_err(`SDL_ERR_CMD))
    else $error("unknown command not reported");
  a_fmt_cmd: assert property (s_fmt_cmd |=> s_err(`SDL_ERR_FMT))
    else $error("malformed command not reported");
  a_fault_map: assert property (fault_valid && !meas_done
    && !(wr && addr == `SDL_OFF_CMD)
    |=> s_err(listed($past(fault_code)) ? $past(fault_code) : `SDL_ERR_UNK))
    else $error("fault code mapped wrong");
  a_blk_addr: assert property (blk_we |-> blk.addr == 8'(last_q + 8'h01))
    else $error("block address not consecutive");
  a_dense_top: assert property (blk_we && mode_q[30:29] == 2'b00
    |-> blk.data[31:30] == 2'b00)
    else $error("dense block top bits set");
  a_limit_batt: assert property (blk_we && mode_q[30:29] != 2'b00 && !mode_q[28]
    |-> blk.data[19:10] == 10'h0)
    else $error("battery field not zero");
  a_req_pulse: assert property (meas_req |=> !meas_req [*8])
    else $error("sample request too long or too close");
endmodule // sdl_logger_chk
bind sdl_logger sdl_logger_chk sdl_logger_chk_i (.clk(clk), .reset(reset), .addr(addr),
  .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .meas_req(meas_req),
  .meas_done(meas_done), .fault_valid(fault_valid), .fault_code(fault_code),
  .blk_we(blk_we), .blk(blk), .err_valid(err_valid), .err(err));

/* sdl_sensor.sv */
// Purpose: Far side model: oscillator and sensor answering sample requests
// Assumes: Answer three cycles after each request
// Notes:   Raw codes only; the reader side converts them
module sdl_sensor #(parameter int HALF = 8) (
  input wire logic             clk,
  input wire logic             reset,
  input wire logic             meas_req,
  input wire logic [3:0][9:0]  tv,
  output logic                 osc = 1'b0,
  output logic                 meas_done = 1'b0,
  output sdl_pkg::sdl_meas_t   meas = '0,
  output int                   served = 0
);
  timeunit 1ns;
  timeprecision 1ps;
  int         oc = 0;
  logic [1:0] pend = 2'b00;
  always @(posedge clk) begin
    oc <= (oc == HALF - 1) ? 0 : oc + 1;
    if (oc == HALF - 1) osc <= ~osc;
    pend <= {pend[0], meas_req};
    meas_done <= pend[1];
    // Raw codes handed over unconverted
    if (pend[1]) begin
      meas <= {tv[served > 3 ? 3 : served], 10'h155, 2'b00};
      served <= served + 1;
    end else meas <= ~meas;
    if (reset) begin
      pend <= 2'b00;
      served <= 0;
      meas_done <= 1'b0;
    end
  end
endmodule // sdl_sensor

/* sdl_logger_tb.sv */
// Purpose: Bench for sdl_logger: commands, faults, log forms, irq
// Assumes: OSC_HZ 4 and DELAY_UNIT_S 1, one second is 64 clocks
// Notes:   Partner sdl_sensor makes the oscillator and samples
`include "sdl_cfg.svh"
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin err_total++; \
  $display("[ERR] %0t got %h exp %h", $time, (a), (b)); end end
module sdl_logger_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int SEC = 64;
  logic clk = 0, reset = 1, wr = 0, rd = 0, fault_valid = 0;
  logic [7:0] addr = 0, fault_code = 0;
  logic [31:0] wdata = 0, rdata, rv;
  logic osc_in, meas_req, meas_done, blk_we, err_valid, irq;
  logic [3:0][9:0] tv = '0;
  sdl_pkg::sdl_meas_t meas;
  sdl_pkg::sdl_blk_t blk;
  sdl_pkg::sdl_err_t err;
  int served, err_total = 0, check_count = 0, cyc = 0, last_req = 0, gap = 0;
  logic [31:0] q[$];
  logic [7:0] codes [0:12] = '{8'h01, 8'h02, 8'h03, 8'h0F, 8'h10, 8'h11, 8'h12,
                               8'hA0, 8'hA1, 8'hA2, 8'hA3, 8'hA5, 8'hA6};
  sdl_logger #(.OSC_HZ(4), .DELAY_UNIT_S(1)) sdl_logger_i (.clk(clk), .reset(reset),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .osc_in(osc_in),
    .meas_req(meas_req), .meas_done(meas_done), .meas(meas), .fault_valid(fault_valid),
    .fault_code(fault_code), .blk_we(blk_we), .blk(blk), .err_valid(err_valid),
    .err(err), .irq(irq));
  sdl_sensor #(.HALF(8)) sdl_sensor_i (.clk(clk), .reset(reset), .meas_req(meas_req),
    .tv(tv), .osc(osc_in), .meas_done(meas_done), .meas(meas), .served(served));
  initial forever #2 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (blk_we === 1'b1) q.push_back(blk.data);
    if (meas_req === 1'b1) begin
      if (last_req != 0) gap <= cyc - last_req;
      last_req <= cyc;
    end
  end
  function automatic logic [15:0] crc16(input logic [7:0] c);
    logic [15:0] r;
    logic [15:0] b;
    logic        fb;
    r = `SDL_CRC_PRESET;
    b = {c, `SDL_REPLY_FLAGS};
    for (int i = 0; i < 16; i++) begin
      fb = r[0] ^ b[i];
      r = r >> 1;
      if (fb) r = r ^ `SDL_CRC_POLY;
    end
    return ~r;
  endfunction
  task wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    wr <= 1; addr <= a; wdata <= d;
    @(posedge clk);
    wr <= 0;
  endtask
  task rd_reg(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    rd <= 1; addr <= a;
    @(posedge clk);
    rd <= 0;
    #1 d = rdata;
  endtask
  task chk_err(input logic [7:0] ec);
    if (ec == 8'h00) `CHK(err_valid, 1'b0)
    else begin
      `CHK(err_valid, 1'b1)
      `CHK(err.code, ec)
      `CHK(err.flags, `SDL_REPLY_FLAGS)
      `CHK(err.crc, crc16(ec))
    end
  endtask
  task cmd(input logic [31:0] w, input logic [7:0] ec);
    wr_reg(`SDL_OFF_CMD, w);
    #1 chk_err(ec);
  endtask
  task fault(input logic [7:0] c, input logic [7:0] ec);
    @(posedge clk);
    fault_valid <= 1; fault_code <= c;
    @(posedge clk);
    fault_valid <= 0;
    #1 chk_err(ec);
  endtask
  task run(input logic [31:0] m, l, input logic [15:0] p, input logic [11:0] d, input int n);
    int k;
    @(posedge clk) reset <= 1;
    repeat (3) @(posedge clk);
    reset <= 0;
    q.delete();
    last_req = 0;
    wr_reg(`SDL_OFF_LOG_MODE, m);
    wr_reg(`SDL_OFF_LIMITS, l);
    wr_reg(`SDL_OFF_PERIOD, {16'h0, p});
    wr_reg(`SDL_OFF_INIT_DATA, {20'h0, d});
    cmd(`SDL_CMD_INIT, 8'h00);
    rd_reg(`SDL_OFF_STATUS, rv); `CHK(rv[1:0], 2'h0)
    cmd(`SDL_CMD_START, 8'h00);
    rd_reg(`SDL_OFF_STATUS, rv); `CHK(rv[1:0], 2'h1)
    k = 0;
    while (served < n && k < 5000) begin
      @(posedge clk);
      k++;
    end
    if (k >= 5000) err_total++;
    repeat (4) @(posedge clk);
    #1;
  endtask
  task test_done;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    #100000;
    err_total++;
    test_done();
  end
  initial begin
    repeat (3) @(posedge clk);
    reset <= 0;
    rd_reg(`SDL_OFF_PERIOD, rv); `CHK(rv, {16'h0, `SDL_PERIOD_RST})
    rd_reg(8'h3C, rv); `CHK(rv, 32'h0)
    $display("test reset done");
    cmd(32'h55, `SDL_ERR_CMD);
    cmd(32'h1AC, `SDL_ERR_FMT);
    cmd(`SDL_CMD_START, `SDL_ERR_PARAM);
    cmd(`SDL_CMD_STATE, 8'h00);
    wr_reg(`SDL_OFF_LOG_MODE, 32'h4000_0000);
    cmd(`SDL_CMD_INIT, 8'h00);
    cmd(`SDL_CMD_START, `SDL_ERR_OPT);
    wr_reg(`SDL_OFF_LOG_MODE, 32'h0);
    wr_reg(`SDL_OFF_PERIOD, 32'h0);
    cmd(`SDL_CMD_START, `SDL_ERR_OPT);
    wr_reg(`SDL_OFF_PERIOD, 32'h8001);
    cmd(`SDL_CMD_START, `SDL_ERR_OPT);
    wr_reg(`SDL_OFF_PERIOD, {16'h0, `SDL_PERIOD_MAX});
    cmd(`SDL_CMD_START, 8'h00);
    rd_reg(`SDL_OFF_STATUS, rv); `CHK(rv[1:0], 2'h1)
    $display("test commands done");
    foreach (codes[i]) fault(codes[i], codes[i]);
    fault(8'h04, `SDL_ERR_UNK);
    fault(8'hA4, `SDL_ERR_UNK);
    $display("test faults done");
    tv <= {10'd4, 10'd3, 10'd2, 10'd1};
    run(32'h0, 32'h0, 16'h2, 12'h1, 4);
    `CHK(q.size(), 1)
    `CHK(q[0], {2'b00, 10'd3, 10'd2, 10'd1})
    `CHK(gap, 2 * SEC)
    `CHK(irq, 1'b0)
    wr_reg(`SDL_OFF_IRQ_MASK, 32'h1);
    @(posedge clk);
    #1 `CHK(irq, 1'b1)
    wr_reg(`SDL_OFF_IRQ_STAT, 32'h1);
    @(posedge clk);
    #1 `CHK(irq, 1'b0)
    $display("test dense done");
    tv <= {10'd20, 10'd25, 10'd15, 10'd5};
    run(32'h3000_0000, {12'h0, 10'd20, 10'd10}, 16'h1, 12'h0, 4);
    `CHK(q.size(), 2)
    `CHK(q[0], {12'd1, 10'h155, 10'd5})
    `CHK(q[1], {12'd3, 10'h155, 10'd25})
    rd_reg(`SDL_OFF_OOL_CNT, rv); `CHK(rv, 32'h2)
    $display("test all-out done");
    tv <= {10'd25, 10'd15, 10'd5, 10'd5};
    run(32'h6000_0000, {12'h0, 10'd20, 10'd10}, 16'h1, 12'h0, 4);
    `CHK(q.size(), 2)
    `CHK(q[0], {12'd1, 10'h0, 10'd5})
    `CHK(q[1], {12'd4, 10'h0, 10'd25})
    rd_reg(`SDL_OFF_OOL_CNT, rv); `CHK(rv, 32'h3)
    $display("test crossing done");
    test_done();
  end
endmodule // sdl_logger_tb
